// >>> inc/psu_cmd_pkg.sv
// Constants, encodings and carrier types for the power unit command slave.
// Assumes a single system clock; all users import the whole package.
package psu_cmd_pkg;

    // Default seven-bit bus address of the slave.
    localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h2A;

    // Header layout: length field on top, module field below.
    localparam int HDR_LEN_MSB = 7;
    localparam int HDR_LEN_LSB = 5;
    localparam int HDR_MOD_MSB = 4;
    localparam int HDR_MOD_LSB = 0;

    // Command and reply module codes.
    localparam logic [4:0] MOD_BOOT_PRIMARY = 5'h1F;
    localparam logic [4:0] MOD_BOOT_ALT     = 5'h1E;
    localparam logic [4:0] MOD_WD_CLEAR     = 5'h1D;
    localparam logic [4:0] MOD_ON_FIRST     = 5'h19;
    localparam logic [4:0] MOD_ON_LAST      = 5'h1C;
    localparam logic [4:0] MOD_OFF_FIRST    = 5'h15;
    localparam logic [4:0] MOD_OFF_LAST     = 5'h18;
    localparam logic [4:0] MOD_INVALID      = 5'h14;
    localparam logic [4:0] MOD_VALID        = 5'h13;
    localparam logic [4:0] MOD_BEACON_ON    = 5'h12;
    localparam logic [4:0] MOD_BEACON_OFF   = 5'h11;
    localparam logic [4:0] MOD_CONV_FIXED   = 5'h0C;
    localparam logic [4:0] MOD_CONV_DIGITAL = 5'h0B;
    localparam logic [4:0] MOD_HK_FIRST     = 5'h01;
    localparam logic [4:0] MOD_HK_LAST      = 5'h09;
    localparam logic [4:0] MOD_HK_STATUS    = 5'h05;
    localparam logic [4:0] MOD_HK_HOSTRST   = 5'h09;

    // Housekeeping geometry and reply buffer size.
    localparam int         HK_RECORDS = 9;
    localparam int         REPLY_MAX  = 6;
    localparam logic [2:0] REPLY_LEN_HK  = 3'h6;
    localparam logic [2:0] REPLY_LEN_ACK = 3'h2;
    localparam logic [2:0] LEN_FIELD_HK  = 3'h3;
    localparam logic [7:0] IDLE_BYTE     = 8'hFF;

    // Reset values of the control state.
    localparam logic       BOOT_ALT_RST   = 1'b0;
    localparam logic [3:0] LOADS_RST      = 4'h0;
    localparam logic       BEACON_RST     = 1'b1;
    localparam logic       CONV_FIXED_RST = 1'b1;
    localparam logic       RST_FLAG_RST   = 1'b1;

    // Power outputs; bit order follows the module codes 25 to 28.
    typedef struct packed {
        logic radio_subsystem;
        logic camera_load;
        logic attitude_control;
        logic host_computer;
    } load_power_t;

    // Conditioned bus pins and the events seen on them.
    typedef struct packed {
        logic scl;
        logic sda;
        logic scl_rise;
        logic scl_fall;
        logic start;
        logic stop;
    } pin_events_t;

    // Byte engine states, one-hot.
    typedef enum logic [6:0] {
        LK_IDLE     = 7'h01,
        LK_ADDR     = 7'h02,
        LK_ADDR_ACK = 7'h04,
        LK_WR_BYTE  = 7'h08,
        LK_WR_ACK   = 7'h10,
        LK_RD_BYTE  = 7'h20,
        LK_RD_ACK   = 7'h40
    } link_state_t;

endpackage

// >>> logic/bus_pin_conditioner.sv
// Two-flop synchroniser for the bus pins plus edge, START and STOP detection.
// Assumes the system clock is many times faster than the bus clock.
`timescale 1ns/1ns
module bus_pin_conditioner
    import psu_cmd_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output pin_events_t      pins
);

    // Bit 1 carries the clock line, bit 0 the data line.
    typedef struct packed {
        logic [1:0] meta;
        logic [1:0] sync;
        logic [1:0] prev;
    } cond_state_t;

    cond_state_t s_r;
    cond_state_t s_nxt;

    // The first stage feeds only the second; events use the later stages.
    always_comb begin
        s_nxt      = s_r;
        s_nxt.meta = {scl_in, sda_in};
        s_nxt.sync = s_r.meta;
        s_nxt.prev = s_r.sync;
    end

    // Idle bus is high on both lines.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s_r <= '{meta: 2'h3, sync: 2'h3, prev: 2'h3};
        end else begin
            s_r <= s_nxt;
        end
    end

    // Data changing while the clock stays high marks START or STOP.
    assign pins.scl      = s_r.sync[1];
    assign pins.sda      = s_r.sync[0];
    assign pins.scl_rise = s_r.sync[1] & ~s_r.prev[1];
    assign pins.scl_fall = ~s_r.sync[1] & s_r.prev[1];
    assign pins.start    = s_r.sync[1] & s_r.prev[1] & s_r.prev[0] & ~s_r.sync[0];
    assign pins.stop     = s_r.sync[1] & s_r.prev[1] & ~s_r.prev[0] & s_r.sync[0];

endmodule // bus_pin_conditioner

// >>> logic/power_unit_i2c_command_slave.sv
// Bus slave and command interpreter of the power unit.
// Assumes one bus master, pins conditioned on core_clk, and open-drain data.
`timescale 1ns/1ns
module power_unit_i2c_command_slave
    import psu_cmd_pkg::*;
#(
    parameter logic [6:0] OWN_ADDR = SLAVE_ADDR_DEFAULT
) (
    input  wire logic                              core_clk,
    input  wire logic                              rst_n,
    input  wire logic                              scl_in,
    input  wire logic                              sda_in,
    output      logic                              sda_out,
    output      logic                              sda_oe,
    input  wire logic [HK_RECORDS-1:0][31:0]       hk_meas,
    input  wire logic                              spare_load_bit,
    input  wire logic                              watchdog_timeout,
    output      logic                              boot_alt_image,
    output      load_power_t                       load_power,
    output      logic                              beacon_enable,
    output      logic                              converter_fixed,
    output      logic                              watchdog_clear
);

    typedef struct packed {
        link_state_t                   fsm;
        logic [3:0]                    bit_cnt;
        logic [7:0]                    shreg;
        logic                          is_read;
        logic [3:0]                    rx_cnt;
        logic [7:0]                    header;
        logic [7:0]                    sum;
        logic [7:0]                    last;
        logic [REPLY_MAX-1:0][7:0]     reply;
        logic [2:0]                    reply_len;
        logic [2:0]                    tx_idx;
        logic                          sda_oe;
        logic                          boot_alt;
        logic [3:0]                    loads;
        logic                          beacon;
        logic                          conv_fixed;
        logic                          wd_clear;
        logic                          rst_flag;
        logic [15:0]                   host_resets;
    } slave_state_t;

    slave_state_t s_r;
    slave_state_t s_nxt;
    pin_events_t  pe;

    // Pin synchroniser and bus condition detector.
    bus_pin_conditioner u_pins (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .scl_in   (scl_in),
        .sda_in   (sda_in),
        .pins     (pe)
    );

    // True for a zero-length command code that changes an output.
    function automatic logic is_command(input logic [4:0] m);
        is_command = (m == MOD_BOOT_PRIMARY) || (m == MOD_BOOT_ALT) ||
                     (m == MOD_WD_CLEAR) ||
                     ((m >= MOD_OFF_FIRST) && (m <= MOD_ON_LAST)) ||
                     (m == MOD_BEACON_ON) || (m == MOD_BEACON_OFF) ||
                     (m == MOD_CONV_FIXED) || (m == MOD_CONV_DIGITAL);
    endfunction

    // Reply byte at a position, idle ones beyond the end.
    function automatic logic [7:0] reply_byte(input slave_state_t st, input logic [2:0] idx);
        if (idx < st.reply_len) begin
            reply_byte = st.reply[idx];
        end else begin
            reply_byte = IDLE_BYTE;
        end
    endfunction

    // Frame decode, evaluated when STOP closes a write frame.
    logic [2:0]  hdr_len;
    logic [4:0]  hdr_mod;
    logic [3:0]  data_cnt;
    logic [7:0]  calc_sum;
    logic        frame_done;
    logic        ck_ok;
    logic        cmd_ok;
    logic        is_hk;
    logic [7:0]  next_tx;

    assign hdr_len    = s_r.header[HDR_LEN_MSB:HDR_LEN_LSB];
    assign hdr_mod    = s_r.header[HDR_MOD_MSB:HDR_MOD_LSB];
    assign data_cnt   = s_r.rx_cnt - 4'h2;
    assign calc_sum   = s_r.sum - s_r.last;
    assign frame_done = pe.stop && !s_r.is_read && (s_r.rx_cnt != 4'h0) &&
                        ((s_r.fsm == LK_WR_BYTE) || (s_r.fsm == LK_WR_ACK));
    assign ck_ok      = (s_r.rx_cnt >= 4'h2) && ((s_r.last - calc_sum) == 8'h00) &&
                        ((data_cnt == 4'h0) ||
                         (data_cnt == ({1'b0, hdr_len} + 4'h1)));
    assign cmd_ok     = frame_done && ck_ok && (hdr_len == 3'h0);
    assign is_hk      = (hdr_mod >= MOD_HK_FIRST) && (hdr_mod <= MOD_HK_LAST);
    assign next_tx    = reply_byte(s_r, s_r.tx_idx + 3'h1);

    // Next state: byte engine, frame processing and housekeeping counters.
    always_comb begin
        logic [4:0]  ofs;
        logic [31:0] rec;
        logic [7:0]  rsum;
        logic [7:0]  b0;
        ofs        = 5'h00;
        rec        = 32'h0000_0000;
        rsum       = 8'h00;
        b0         = reply_byte(s_r, 3'h0);
        s_nxt      = s_r;
        s_nxt.wd_clear = 1'b0;
        if (watchdog_timeout) begin
            s_nxt.host_resets = s_r.host_resets + 16'h0001;
        end
        if (pe.start) begin
            s_nxt.fsm     = LK_ADDR;
            s_nxt.bit_cnt = 4'h0;
            s_nxt.rx_cnt  = 4'h0;
            s_nxt.sum     = 8'h00;
            s_nxt.is_read = 1'b0;
            s_nxt.sda_oe  = 1'b0;
        end else if (pe.stop) begin
            s_nxt.fsm    = LK_IDLE;
            s_nxt.sda_oe = 1'b0;
            if (frame_done) begin
                s_nxt.wd_clear  = 1'b1;
                s_nxt.reply[0]  = {3'h0, MOD_INVALID};
                s_nxt.reply[1]  = {3'h0, MOD_INVALID};
                s_nxt.reply_len = REPLY_LEN_ACK;
                if (cmd_ok && is_command(hdr_mod)) begin
                    s_nxt.reply[0] = {3'h0, MOD_VALID};
                    s_nxt.reply[1] = {3'h0, MOD_VALID};
                    if (hdr_mod == MOD_BOOT_PRIMARY) begin
                        s_nxt.boot_alt = 1'b0;
                    end else if (hdr_mod == MOD_BOOT_ALT) begin
                        s_nxt.boot_alt = 1'b1;
                    end else if ((hdr_mod >= MOD_ON_FIRST) && (hdr_mod <= MOD_ON_LAST)) begin
                        ofs = hdr_mod - MOD_ON_FIRST;
                        s_nxt.loads[ofs[1:0]] = 1'b1;
                    end else if ((hdr_mod >= MOD_OFF_FIRST) && (hdr_mod <= MOD_OFF_LAST)) begin
                        ofs = hdr_mod - MOD_OFF_FIRST;
                        s_nxt.loads[ofs[1:0]] = 1'b0;
                    end else if (hdr_mod == MOD_BEACON_ON) begin
                        s_nxt.beacon = 1'b1;
                    end else if (hdr_mod == MOD_BEACON_OFF) begin
                        s_nxt.beacon = 1'b0;
                    end else if (hdr_mod == MOD_CONV_FIXED) begin
                        s_nxt.conv_fixed = 1'b1;
                    end else if (hdr_mod == MOD_CONV_DIGITAL) begin
                        s_nxt.conv_fixed = 1'b0;
                    end
                end else if (cmd_ok && is_hk) begin
                    ofs = hdr_mod - MOD_HK_FIRST;
                    rec = hk_meas[ofs[3:0]];
                    if (hdr_mod == MOD_HK_STATUS) begin
                        rec[15:8] = {7'h00, s_r.rst_flag};
                        rec[7:0]  = {4'h0, s_r.loads[1], s_r.loads[2],
                                     spare_load_bit, s_r.loads[0]};
                        s_nxt.rst_flag = 1'b0;
                    end
                    if (hdr_mod == MOD_HK_HOSTRST) begin
                        rec[31:16] = s_r.host_resets;
                    end
                    s_nxt.reply[0] = {LEN_FIELD_HK, hdr_mod};
                    s_nxt.reply[1] = rec[31:24];
                    s_nxt.reply[2] = rec[23:16];
                    s_nxt.reply[3] = rec[15:8];
                    s_nxt.reply[4] = rec[7:0];
                    rsum = s_nxt.reply[0] + rec[31:24] + rec[23:16] + rec[15:8] + rec[7:0];
                    s_nxt.reply[5]  = rsum;
                    s_nxt.reply_len = REPLY_LEN_HK;
                end
            end
        end else begin
            case (s_r.fsm)
                LK_ADDR, LK_WR_BYTE: begin
                    if (pe.scl_rise && (s_r.bit_cnt < 4'h8)) begin
                        s_nxt.shreg   = {s_r.shreg[6:0], pe.sda};
                        s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
                    end else if (pe.scl_fall && (s_r.bit_cnt == 4'h8)) begin
                        if (s_r.fsm == LK_ADDR) begin
                            if (s_r.shreg[7:1] == OWN_ADDR) begin
                                s_nxt.fsm     = LK_ADDR_ACK;
                                s_nxt.sda_oe  = 1'b1;
                                s_nxt.is_read = s_r.shreg[0];
                            end else begin
                                s_nxt.fsm = LK_IDLE;
                            end
                        end else begin
                            if (s_r.rx_cnt == 4'h0) begin
                                s_nxt.header = s_r.shreg;
                            end
                            if (s_r.rx_cnt != 4'hF) begin
                                s_nxt.rx_cnt = s_r.rx_cnt + 4'h1;
                            end
                            s_nxt.sum    = s_r.sum + s_r.shreg;
                            s_nxt.last   = s_r.shreg;
                            s_nxt.fsm    = LK_WR_ACK;
                            s_nxt.sda_oe = 1'b1;
                        end
                    end
                end
                LK_ADDR_ACK: begin
                    if (pe.scl_fall) begin
                        s_nxt.bit_cnt = 4'h0;
                        if (s_r.is_read) begin
                            s_nxt.fsm    = LK_RD_BYTE;
                            s_nxt.tx_idx = 3'h0;
                            s_nxt.shreg  = b0;
                            s_nxt.sda_oe = ~b0[7];
                        end else begin
                            s_nxt.fsm    = LK_WR_BYTE;
                            s_nxt.sda_oe = 1'b0;
                        end
                    end
                end
                LK_WR_ACK: begin
                    if (pe.scl_fall) begin
                        s_nxt.fsm     = LK_WR_BYTE;
                        s_nxt.bit_cnt = 4'h0;
                        s_nxt.sda_oe  = 1'b0;
                    end
                end
                LK_RD_BYTE: begin
                    if (pe.scl_fall) begin
                        s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
                        if (s_r.bit_cnt == 4'h7) begin
                            s_nxt.fsm    = LK_RD_ACK;
                            s_nxt.sda_oe = 1'b0;
                        end else begin
                            s_nxt.shreg  = {s_r.shreg[6:0], 1'b0};
                            s_nxt.sda_oe = ~s_r.shreg[6];
                        end
                    end
                end
                LK_RD_ACK: begin
                    if (pe.scl_rise && pe.sda) begin
                        s_nxt.fsm = LK_IDLE;
                    end else if (pe.scl_fall) begin
                        s_nxt.fsm     = LK_RD_BYTE;
                        s_nxt.tx_idx  = s_r.tx_idx + 3'h1;
                        s_nxt.bit_cnt = 4'h0;
                        s_nxt.shreg   = next_tx;
                        s_nxt.sda_oe  = ~next_tx[7];
                    end
                end
                default: begin
                    s_nxt.fsm    = LK_IDLE;
                    s_nxt.sda_oe = 1'b0;
                end
            endcase
        end
    end

    // State register with defined reset values.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s_r             <= '0;
            s_r.fsm         <= LK_IDLE;
            s_r.reply[0]    <= {3'h0, MOD_INVALID};
            s_r.reply[1]    <= {3'h0, MOD_INVALID};
            s_r.reply_len   <= REPLY_LEN_ACK;
            s_r.boot_alt    <= BOOT_ALT_RST;
            s_r.loads       <= LOADS_RST;
            s_r.beacon      <= BEACON_RST;
            s_r.conv_fixed  <= CONV_FIXED_RST;
            s_r.rst_flag    <= RST_FLAG_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs other than the constant-low sda_out come straight from the state register.
    assign sda_out         = 1'b0;
    assign sda_oe          = s_r.sda_oe;
    assign boot_alt_image  = s_r.boot_alt;
    assign load_power      = load_power_t'(s_r.loads);
    assign beacon_enable   = s_r.beacon;
    assign converter_fixed = s_r.conv_fixed;
    assign watchdog_clear  = s_r.wd_clear;

    // Checks on the byte engine and on command effects.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    property p_addr_ack;
        (s_r.fsm == LK_ADDR) && pe.scl_fall && (s_r.bit_cnt == 4'h8) &&
        (s_r.shreg[7:1] == OWN_ADDR) && !pe.start && !pe.stop |=> sda_oe;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("address not acknowledged");

    property p_foreign;
        (s_r.fsm == LK_ADDR) && pe.scl_fall && (s_r.bit_cnt == 4'h8) &&
        (s_r.shreg[7:1] != OWN_ADDR) && !pe.start && !pe.stop |=> !sda_oe [*2];
    endproperty
    a_foreign: assert property (p_foreign) else $error("foreign address acknowledged");

    property p_stop_idle;
        pe.stop && !pe.start |=> (s_r.fsm == LK_IDLE) && !sda_oe;
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("stop did not idle");

    property p_wd_any;
        frame_done |=> watchdog_clear ##1 !watchdog_clear;
    endproperty
    a_wd_any: assert property (p_wd_any) else $error("watchdog clear missing");

    property p_boot;
        cmd_ok && (hdr_mod == MOD_BOOT_ALT) |=> boot_alt_image;
    endproperty
    a_boot: assert property (p_boot) else $error("boot select not high");

    property p_load_on;
        cmd_ok && (hdr_mod == MOD_ON_LAST) |=> load_power.radio_subsystem;
    endproperty
    a_load_on: assert property (p_load_on) else $error("radio power not on");

    property p_invalid;
        frame_done && !ck_ok |=> (s_r.reply[0] == {3'h0, MOD_INVALID}) &&
                                 $stable(load_power) && $stable(boot_alt_image);
    endproperty
    a_invalid: assert property (p_invalid) else $error("bad frame not rejected");

    property p_hk_len;
        cmd_ok && is_hk |=> (s_r.reply_len == REPLY_LEN_HK) &&
                            (s_r.reply[0][HDR_LEN_MSB:HDR_LEN_LSB] == LEN_FIELD_HK);
    endproperty
    a_hk_len: assert property (p_hk_len) else $error("record length wrong");

    property p_rst_flag;
        cmd_ok && (hdr_mod == MOD_HK_STATUS) |=> !s_r.rst_flag;
    endproperty
    a_rst_flag: assert property (p_rst_flag) else $error("reset flag not cleared");

    c_cmd:  cover property (cmd_ok && is_command(hdr_mod));
    c_hk:   cover property (cmd_ok && is_hk);
    c_bad:  cover property (frame_done && !ck_ok);
    c_read: cover property ((s_r.fsm == LK_RD_ACK) ##[1:1000] (s_r.fsm == LK_RD_BYTE));

endmodule // power_unit_i2c_command_slave

// >>> testbench/obc_master_model.sv
// Onboard computer model: the only bus master, driving SCL and pulling SDA low.
// Assumes the bench resolves SDA from both pull-downs and a pull-up.
`timescale 1ns/1ns
module obc_master_model (
    input  wire logic link_clk,
    input  wire logic sda,
    output      logic scl = 1'b1,
    output      logic sda_low = 1'b0
);
    // A third of an SCL period, timed on the link clock.
    task automatic hp(); repeat (6) @(posedge link_clk); endtask
    // START from idle: SDA falls while SCL is high.
    task automatic start(); sda_low = 1; hp(); scl = 0; hp(); endtask
    // Nine bits MSB first; a 1 releases SDA so the slave may drive it.
    task automatic bits(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) begin
            sda_low = !d[i]; hp(); scl = 1; hp(); q[i] = sda; scl = 0; hp();
        end
    endtask
    // STOP: SDA rises while SCL is high, leaving the bus idle.
    task automatic stop(); sda_low = 1; hp(); scl = 1; hp(); sda_low = 0; hp(); endtask
endmodule // obc_master_model

// >>> testbench/power_unit_i2c_command_slave_bench.sv
// Bench for the power unit command slave: commands and housekeeping reads.
// Assumes the master model is compiled first; SDA is open drain with a pull-up.
`timescale 1ns/1ns
module power_unit_i2c_command_slave_bench;
    import psu_cmd_pkg::*;
    logic core_clk = 0, link_clk = 0, rst_n = 0, spare_load_bit = 0, watchdog_timeout = 0;
    logic scl_in, sda_in, sda_out, sda_oe, sda_low, boot_alt_image, beacon_enable;
    logic converter_fixed, watchdog_clear, e_boot = 0, e_beac = 1, e_conv = 1, rflag = 1;
    logic [HK_RECORDS-1:0][31:0] hk_meas = '0;
    load_power_t load_power, e_load = '0;
    logic [15:0] wdc = 0;
    int num_errors = 0, n_checks = 0, clr = 0, cyc = 0;
    power_unit_i2c_command_slave i_dut (.*);
    obc_master_model m (.link_clk, .sda(sda_in), .scl(scl_in), .sda_low);
    // Open-drain data wire with a pull-up.
    assign sda_in = !(sda_oe | sda_low);
    // Core and link clocks, unrelated in phase.
    initial forever #10 core_clk = !core_clk;
    initial begin #7; forever #15 link_clk = !link_clk; end
    // Counts clear pulses and cuts a hang short.
    always @(posedge core_clk) begin
        clr <= clr + watchdog_clear;
        cyc <= cyc + 1;
        if (cyc == 90000) begin num_errors++; results(); end
    end
    // Compares one value and reports a mismatch.
    task automatic chk(input logic [31:0] seen, exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic results();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Sends START and the own address with a direction bit.
    task automatic adr(input logic rd);
        logic [8:0] q;
        m.start();
        m.bits({SLAVE_ADDR_DEFAULT, rd, 1'b1}, q);
        chk(q[0], 0, "address ack");
    endtask
    // Reads n reply bytes, acknowledging all but the last.
    task automatic rd(input logic [7:0] e[6], input int n);
        logic [8:0] q;
        adr(1);
        for (int k = 0; k < n; k++) begin
            m.bits({8'hFF, k == n - 1}, q);
            chk(q[8:1], e[k], "reply byte");
        end
        m.stop();
    endtask
    initial begin
        logic [4:0] cmd[15] = '{31, 30, 29, 25, 26, 27, 28, 21, 22, 23, 24, 18, 17, 12, 11};
        logic [7:0] h, e[6];
        logic [8:0] q;
        logic [31:0] r;
        logic [4:0] md;
        logic v;
        void'($urandom(32'h09D1));
        foreach (hk_meas[k]) hk_meas[k] = $urandom();
        repeat (12) @(posedge core_clk);
        #2 rst_n = 1;
        repeat (4) @(posedge core_clk);
        m.start();
        m.bits({7'h15, 2'b01}, q);
        m.stop();
        chk(q[0], 1, "foreign ack");
        for (int i = 0; i < 26; i++) begin
            md = i < 15 ? cmd[i] : i < 17 ? 5'h05 : 5'($urandom_range(0, 10));
            h = {i == 20 ? 3'h1 : 3'h0, md};
            v = i % 6 != 5 && i != 20 && md inside {[1:9], 11, 12, 17, 18, [21:31]};
            #2 spare_load_bit = $urandom();
            watchdog_timeout = $urandom();
            wdc += watchdog_timeout;
            @(posedge core_clk);
            #2 watchdog_timeout = 0;
            // Header then checksum; every sixth checksum is spoilt.
            adr(0);
            for (int k = 0; k < 2; k++) begin
                m.bits({k ? h + (i % 6 == 5) : h, 1'b1}, q);
                chk(q[0], 0, "byte ack");
            end
            m.stop();
            chk(clr, i + 1, "watchdog clears");
            if (v) case (md) inside
                30, 31: e_boot = !md[0];
                [25:28]: e_load[md - 25] = 1;
                [21:24]: e_load[md - 21] = 0;
                17, 18: e_beac = !md[0];
                11, 12: e_conv = !md[0];
                default: ;
            endcase
            chk({boot_alt_image, load_power, beacon_enable, converter_fixed},
                {e_boot, e_load, e_beac, e_conv}, "controls");
            r = md == 9 ? {wdc, hk_meas[8][15:0]} : hk_meas[md - 1];
            if (md == 5) r[15:0] = {7'h0, rflag, 4'h0, e_load.attitude_control,
                e_load.camera_load, spare_load_bit, e_load.host_computer};
            if (v && md < 10) begin
                e = '{{3'h3, md}, r[31:24], r[23:16], r[15:8], r[7:0], 8'h00};
                e[5] = e[0] + e[1] + e[2] + e[3] + e[4];
                rflag &= md != 5;
            end else e = '{6{{3'h0, v ? 5'h13 : 5'h14}}};
            rd(e, v && md < 10 ? 6 : 2);
        end
        results();
    end
endmodule // power_unit_i2c_command_slave_bench
